// File: pkg/csd_pkg.sv
/*
  csd_pkg: constants and types of the configuration space decoder.
  assumes every requester and register group shares the one hub clock.
*/
package csd_pkg;
  localparam logic [15:0] IO_CFG_ADDR = 16'h0cf8;
  localparam logic [15:0] IO_CFG_DATA = 16'h0cfc;
  localparam logic [3:0] BE_DWORD = 4'hf;
  localparam logic [31:0] ALL_ONES = 32'hffff_ffff;
  localparam logic [31:0] ALL_ZERO = 32'h0000_0000;
  localparam int LATCH_EN_BIT = 31;
  localparam int LATCH_BUS_LSB = 16;
  localparam int LATCH_DEV_LSB = 11;
  localparam int LATCH_FN_LSB = 8;
  localparam int LATCH_DW_LSB = 2;
  localparam logic [31:0] LATCH_RESET = 32'h0000_0000;
  localparam logic [31:0] LATCH_WR_MASK = 32'h80ff_fffc;
  localparam int MCW_BASE_LSB = 28;
  localparam int MCW_BUS_LSB = 20;
  localparam int MCW_DEV_LSB = 15;
  localparam int MCW_FN_LSB = 12;
  localparam int MCW_DW_LSB = 2;
  localparam int FIXED_TAG_LSB = 20;
  localparam logic [11:0] FIXED_WIN_TAG = 12'hfe6;
  localparam int FIXED_DW_LSB = 10;
  localparam int WIN4K_LSB = 12;
  localparam int MB_BASE_LSB = 24;
  localparam int MB_ZERO_LSB = 15;
  localparam int MB_BRANCH_BIT = 14;
  localparam int MB_CHAN_BIT = 13;
  localparam int MB_MOD_LSB = 10;
  localparam int MB_DW_LSB = 2;
  localparam logic [4:0] DEV_LINK = 5'h00;
  localparam logic [4:0] DEV_PORT_FIRST = 5'h01;
  localparam logic [4:0] DEV_PORT_LAST = 5'h09;
  localparam logic [4:0] DEV_SHARED_LO = 5'h0d;
  localparam logic [4:0] DEV_SHARED_HI = 5'h0e;
  localparam logic [4:0] DEV_PROC = 5'h10;
  localparam logic [4:0] DEV_COHERENCY = 5'h11;
  localparam logic [4:0] DEV_IOINT = 5'h12;
  localparam logic [4:0] DEV_BRANCH0 = 5'h15;
  localparam logic [4:0] DEV_BRANCH1 = 5'h16;
  localparam logic [2:0] FN_SHARED_LAST = 3'h4;
  localparam logic [2:0] FN_PROC_LAST = 3'h2;
  localparam logic [2:0] FN_BRANCH_LAST = 3'h1;
  localparam logic [4:0] LANES_X16 = 5'h10;
  localparam logic [4:0] LANES_X8 = 5'h08;
  localparam logic [4:0] LANES_X4 = 5'h04;
  localparam logic [1:0] LINK_TYPE0 = 2'h0;
  localparam logic [1:0] LINK_TYPE1 = 2'h1;

  typedef enum logic [2:0] {
    SRC_CPU_IO, SRC_CPU_MEM, SRC_JTAG, SRC_SMBUS, SRC_LINK_CFG, SRC_LINK_MEM
  } csd_src_type;

  typedef enum logic [3:0] {
    GRP_NONE, GRP_LINK_BRIDGE, GRP_PCIE_PORT, GRP_PORT_SHARED_LO, GRP_PORT_SHARED_HI,
    GRP_PROC_BUS, GRP_COHERENCY, GRP_IOINT, GRP_MEM_BRANCH, GRP_REMAP
  } csd_group_type;

  typedef enum logic [2:0] {
    K_LATCH_WR, K_LATCH_RD, K_PASS, K_ABORT, K_GRP, K_SBL, K_MB
  } csd_kind_type;
endpackage : csd_pkg

// File: hw/csd_addr_latch.sv
/*
  csd_addr_latch: the config_address_latch behind the io address port.
  assumes the caller strobes wr_en only for dword writes to that port.
*/
`timescale 1ns/100ps
module csd_addr_latch (
  input logic clk_sys,
  input logic srst,
  input logic ce,
  input logic wr_en,
  input logic [31:0] wdata,
  output logic [31:0] latch_value,
  output logic config_cycle_enable,
  output logic [7:0] bus,
  output logic [4:0] dev,
  output logic [2:0] fn,
  output logic [5:0] dword
);
  logic [31:0] latch_reg;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      latch_reg <= csd_pkg::LATCH_RESET;
    else if (ce && wr_en)
      latch_reg <= wdata & csd_pkg::LATCH_WR_MASK;
  end

  assign latch_value = latch_reg;
  assign config_cycle_enable = latch_reg[csd_pkg::LATCH_EN_BIT];
  assign bus = latch_reg[csd_pkg::LATCH_BUS_LSB +: 8];
  assign dev = latch_reg[csd_pkg::LATCH_DEV_LSB +: 5];
  assign fn = latch_reg[csd_pkg::LATCH_FN_LSB +: 3];
  assign dword = latch_reg[csd_pkg::LATCH_DW_LSB +: 6];
endmodule : csd_addr_latch

// File: hw/csd_target_map.sv
/*
  csd_target_map: bus 0 device and function to register group lookup.
  assumes purely combinational use by the decoder on the same cycle.
*/
`timescale 1ns/100ps
module csd_target_map (
  input logic [4:0] dev,
  input logic [2:0] fn,
  output logic dev_hit,
  output logic fn_hit,
  output csd_pkg::csd_group_type group,
  output logic [4:0] max_lanes
);
  always_comb
  begin
    dev_hit = 1'b1;
    fn_hit = 1'b0;
    group = csd_pkg::GRP_NONE;
    max_lanes = 5'h00;
    if (dev >= csd_pkg::DEV_PORT_FIRST && dev <= csd_pkg::DEV_PORT_LAST)
    begin
      group = csd_pkg::GRP_PCIE_PORT;
      fn_hit = (fn == 3'h0);
      unique case (dev)
        5'h01, 5'h05: max_lanes = csd_pkg::LANES_X16;
        5'h03, 5'h07: max_lanes = csd_pkg::LANES_X8;
        default: max_lanes = csd_pkg::LANES_X4;
      endcase
    end
    else
    begin
      unique case (dev)
        csd_pkg::DEV_LINK:
        begin
          group = csd_pkg::GRP_LINK_BRIDGE;
          fn_hit = (fn == 3'h0);
        end
        csd_pkg::DEV_SHARED_LO:
        begin
          group = csd_pkg::GRP_PORT_SHARED_LO;
          fn_hit = (fn <= csd_pkg::FN_SHARED_LAST);
        end
        csd_pkg::DEV_SHARED_HI:
        begin
          group = csd_pkg::GRP_PORT_SHARED_HI;
          fn_hit = (fn <= csd_pkg::FN_SHARED_LAST);
        end
        csd_pkg::DEV_PROC:
        begin
          group = csd_pkg::GRP_PROC_BUS;
          fn_hit = (fn <= csd_pkg::FN_PROC_LAST);
        end
        csd_pkg::DEV_COHERENCY:
        begin
          group = csd_pkg::GRP_COHERENCY;
          fn_hit = (fn == 3'h0);
        end
        csd_pkg::DEV_IOINT:
        begin
          group = csd_pkg::GRP_IOINT;
          fn_hit = (fn == 3'h0);
        end
        csd_pkg::DEV_BRANCH0, csd_pkg::DEV_BRANCH1:
        begin
          group = csd_pkg::GRP_MEM_BRANCH;
          fn_hit = (fn <= csd_pkg::FN_BRANCH_LAST);
        end
        default: dev_hit = 1'b0;
      endcase
    end
  end
endmodule : csd_target_map

// File: hw/csd_decoder.sv
/*
  csd_decoder: configuration space decoder and router of the hub.
  assumes requesters, register groups, link and memory-buffer agents all
  run on clk_sys; one request is in flight at a time.
*/
`timescale 1ns/100ps
module csd_decoder (
  input logic clk_sys,
  input logic srst,
  input logic ce,
  input logic req_valid,
  output logic req_ready,
  input csd_pkg::csd_src_type req_src,
  input logic req_write,
  input logic [31:0] req_addr,
  input logic [3:0] req_be,
  input logic [31:0] req_wdata,
  input logic [7:0] req_cfg_bus,
  input logic [4:0] req_cfg_dev,
  input logic [2:0] req_cfg_fn,
  input logic [9:0] req_cfg_dword,
  input logic [3:0] memory_mapped_config_window,
  input logic [7:0] memory_buffer_window_base,
  input logic [19:0] io_interrupt_controller_base,
  input logic [19:0] remap_window_base,
  output logic rsp_valid,
  output logic [31:0] rsp_rdata,
  output logic rsp_abort,
  output logic rsp_passthru,
  output logic grp_valid,
  output csd_pkg::csd_group_type grp_group,
  output logic [4:0] grp_dev,
  output logic [2:0] grp_fn,
  output logic [9:0] grp_dword,
  output logic [3:0] grp_be,
  output logic grp_write,
  output logic [31:0] grp_wdata,
  output logic [4:0] grp_max_lanes,
  input logic grp_ack,
  input logic grp_hit,
  input logic [31:0] grp_rdata,
  output logic grp_wcommit,
  output logic sbl_valid,
  output logic [31:0] sbl_addr,
  output logic sbl_write,
  output logic [3:0] sbl_be,
  output logic [31:0] sbl_wdata,
  input logic sbl_done,
  input logic sbl_abort,
  input logic [31:0] sbl_rdata,
  output logic mb_valid,
  output logic mb_branch,
  output logic mb_channel,
  output logic [2:0] mb_module_select,
  output logic [5:0] mb_dword,
  output logic [3:0] mb_be,
  output logic mb_write,
  output logic [31:0] mb_wdata,
  input logic mb_done,
  input logic [31:0] mb_rdata
);
  typedef enum logic [2:0] {S_IDLE, S_GRP, S_COMMIT, S_SBL, S_MB} csd_state_type;

  csd_state_type state_reg;
  logic write_reg;
  logic [31:0] latch_value;
  logic latch_en;
  logic [7:0] latch_bus;
  logic [4:0] latch_dev;
  logic [2:0] latch_fn;
  logic [5:0] latch_dw;
  logic [7:0] f_bus;
  logic [4:0] f_dev;
  logic [2:0] f_fn;
  logic [9:0] f_dword;
  logic [3:0] f_be;
  logic src_cfg;
  logic src_fixed;
  csd_pkg::csd_group_type mem_group;
  csd_pkg::csd_kind_type src_kind;
  csd_pkg::csd_kind_type kind;
  logic dev_hit;
  logic fn_hit;
  csd_pkg::csd_group_type map_group;
  logic [4:0] map_lanes;
  logic take;
  logic win_ioint;
  logic win_remap;
  logic win_fixed;
  logic win_mcw;
  logic win_mb;

  assign req_ready = ce && (state_reg == S_IDLE);
  assign take = req_valid && req_ready;

  csd_addr_latch u_latch (
    .clk_sys(clk_sys),
    .srst(srst),
    .ce(ce),
    .wr_en(take && (kind == csd_pkg::K_LATCH_WR)),
    .wdata(req_wdata),
    .latch_value(latch_value),
    .config_cycle_enable(latch_en),
    .bus(latch_bus),
    .dev(latch_dev),
    .fn(latch_fn),
    .dword(latch_dw)
  );

  csd_target_map u_map (
    .dev(f_dev),
    .fn(f_fn),
    .dev_hit(dev_hit),
    .fn_hit(fn_hit),
    .group(map_group),
    .max_lanes(map_lanes)
  );

  // memory windows; the 4k windows win over the wider ones
  assign win_ioint = (req_addr[31:csd_pkg::WIN4K_LSB] == io_interrupt_controller_base);
  assign win_remap = (req_addr[31:csd_pkg::WIN4K_LSB] == remap_window_base);
  assign win_fixed = (req_addr[31:csd_pkg::FIXED_TAG_LSB] == csd_pkg::FIXED_WIN_TAG);
  assign win_mcw = (req_addr[31:csd_pkg::MCW_BASE_LSB] == memory_mapped_config_window);
  assign win_mb = (req_addr[31:csd_pkg::MB_BASE_LSB] == memory_buffer_window_base);

  // field extraction per source
  always_comb
  begin
    f_bus = 8'h00;
    f_dev = 5'h00;
    f_fn = 3'h0;
    f_dword = 10'h000;
    f_be = req_be;
    src_cfg = 1'b0;
    src_fixed = 1'b0;
    mem_group = csd_pkg::GRP_NONE;
    src_kind = csd_pkg::K_ABORT;
    unique case (req_src)
      csd_pkg::SRC_CPU_IO:
      begin
        if (req_addr[15:0] == csd_pkg::IO_CFG_ADDR && req_be == csd_pkg::BE_DWORD)
          src_kind = req_write ? csd_pkg::K_LATCH_WR : csd_pkg::K_LATCH_RD;
        else if (req_addr[15:2] == csd_pkg::IO_CFG_DATA[15:2] && latch_en)
        begin
          src_cfg = 1'b1;
          f_bus = latch_bus;
          f_dev = latch_dev;
          f_fn = latch_fn;
          f_dword = {4'h0, latch_dw};
        end
        else
          src_kind = csd_pkg::K_PASS;
      end
      csd_pkg::SRC_CPU_MEM, csd_pkg::SRC_LINK_MEM:
      begin
        src_kind = csd_pkg::K_PASS;
        if (win_ioint || win_remap)
        begin
          src_kind = csd_pkg::K_GRP;
          mem_group = win_ioint ? csd_pkg::GRP_IOINT : csd_pkg::GRP_REMAP;
          f_dev = win_ioint ? csd_pkg::DEV_IOINT : 5'h00;
          f_dword = req_addr[csd_pkg::MCW_DW_LSB +: 10];
        end
        else if (req_src == csd_pkg::SRC_LINK_MEM && (win_fixed || win_mcw || win_mb))
          src_kind = csd_pkg::K_ABORT;
        else if (win_fixed)
        begin
          src_cfg = 1'b1;
          src_fixed = 1'b1;
          f_dev = csd_pkg::DEV_PROC;
          f_dword = {4'h0, req_addr[csd_pkg::FIXED_DW_LSB +: 6]};
          f_be = csd_pkg::BE_DWORD;
        end
        else if (win_mcw)
        begin
          src_cfg = 1'b1;
          f_bus = req_addr[csd_pkg::MCW_BUS_LSB +: 8];
          f_dev = req_addr[csd_pkg::MCW_DEV_LSB +: 5];
          f_fn = req_addr[csd_pkg::MCW_FN_LSB +: 3];
          f_dword = req_addr[csd_pkg::MCW_DW_LSB +: 10];
        end
        else if (win_mb)
        begin
          src_kind = (req_addr[23:csd_pkg::MB_ZERO_LSB] == 9'h000) ?
                     csd_pkg::K_MB : csd_pkg::K_ABORT;
          f_dword = {4'h0, req_addr[csd_pkg::MB_DW_LSB +: 6]};
        end
      end
      csd_pkg::SRC_JTAG, csd_pkg::SRC_SMBUS:
      begin
        src_cfg = 1'b1;
        f_bus = req_cfg_bus;
        f_dev = req_cfg_dev;
        f_fn = req_cfg_fn;
        f_dword = req_cfg_dword;
      end
      csd_pkg::SRC_LINK_CFG: src_kind = csd_pkg::K_ABORT;
      default: src_kind = csd_pkg::K_ABORT;
    endcase
  end

  // routing of configuration targets
  always_comb
  begin
    kind = src_kind;
    if (src_cfg)
    begin
      if (f_bus != 8'h00)
        kind = csd_pkg::K_SBL;
      else if (!dev_hit || !fn_hit)
        kind = csd_pkg::K_ABORT;
      else
        kind = csd_pkg::K_GRP;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      state_reg <= S_IDLE;
    else if (ce)
    begin
      unique case (state_reg)
        S_IDLE:
        begin
          if (req_valid && kind == csd_pkg::K_GRP)
            state_reg <= S_GRP;
          else if (req_valid && kind == csd_pkg::K_SBL)
            state_reg <= S_SBL;
          else if (req_valid && kind == csd_pkg::K_MB)
            state_reg <= S_MB;
        end
        S_GRP:
          if (grp_ack)
            state_reg <= (write_reg && grp_hit) ? S_COMMIT : S_IDLE;
        S_COMMIT: state_reg <= S_IDLE;
        S_SBL:
          if (sbl_done)
            state_reg <= S_IDLE;
        S_MB:
          if (mb_done)
            state_reg <= S_IDLE;
      endcase
    end
  end

  // request fields load on every take; valid marks whether they matter
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      write_reg <= 1'b0;
      grp_group <= csd_pkg::GRP_NONE;
      grp_dev <= 5'h00;
      grp_fn <= 3'h0;
      grp_dword <= 10'h000;
      grp_be <= 4'h0;
      grp_wdata <= 32'h0000_0000;
      grp_max_lanes <= 5'h00;
      sbl_addr <= 32'h0000_0000;
      mb_branch <= 1'b0;
      mb_channel <= 1'b0;
      mb_module_select <= 3'h0;
    end
    else if (take)
    begin
      write_reg <= req_write;
      grp_group <= (src_kind == csd_pkg::K_GRP) ? mem_group : map_group;
      grp_dev <= f_dev;
      grp_fn <= f_fn;
      grp_dword <= f_dword;
      grp_be <= f_be;
      grp_wdata <= req_wdata;
      grp_max_lanes <= map_lanes;
      // extended offset does not travel in the type 1 address
      sbl_addr <= {8'h00, f_bus, f_dev, f_fn, f_dword[5:0], csd_pkg::LINK_TYPE1};
      mb_branch <= req_addr[csd_pkg::MB_BRANCH_BIT];
      mb_channel <= req_addr[csd_pkg::MB_CHAN_BIT];
      mb_module_select <= req_addr[csd_pkg::MB_MOD_LSB +: 3];
    end
  end

  assign grp_write = write_reg;
  assign sbl_write = write_reg;
  assign sbl_be = grp_be;
  assign sbl_wdata = grp_wdata;
  assign mb_write = write_reg;
  assign mb_be = grp_be;
  assign mb_wdata = grp_wdata;
  assign mb_dword = grp_dword[5:0];

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      grp_valid <= 1'b0;
      sbl_valid <= 1'b0;
      mb_valid <= 1'b0;
      grp_wcommit <= 1'b0;
    end
    else if (ce)
    begin
      grp_wcommit <= 1'b0;
      if (take && kind == csd_pkg::K_GRP)
        grp_valid <= 1'b1;
      else if (state_reg == S_GRP && grp_ack)
      begin
        grp_valid <= 1'b0;
        grp_wcommit <= write_reg && grp_hit;
      end
      if (take && kind == csd_pkg::K_SBL)
        sbl_valid <= 1'b1;
      else if (state_reg == S_SBL && sbl_done)
        sbl_valid <= 1'b0;
      if (take && kind == csd_pkg::K_MB)
        mb_valid <= 1'b1;
      else if (state_reg == S_MB && mb_done)
        mb_valid <= 1'b0;
    end
  end

  // answer path; writes always return zero data
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 32'h0000_0000;
      rsp_abort <= 1'b0;
      rsp_passthru <= 1'b0;
    end
    else if (ce)
    begin
      rsp_valid <= 1'b0;
      if (take && kind != csd_pkg::K_GRP && kind != csd_pkg::K_SBL && kind != csd_pkg::K_MB)
      begin
        rsp_valid <= 1'b1;
        rsp_abort <= (kind == csd_pkg::K_ABORT);
        rsp_passthru <= (kind == csd_pkg::K_PASS);
        if (kind == csd_pkg::K_ABORT && !req_write)
          rsp_rdata <= csd_pkg::ALL_ONES;
        else if (kind == csd_pkg::K_LATCH_RD)
          rsp_rdata <= latch_value;
        else
          rsp_rdata <= csd_pkg::ALL_ZERO;
      end
      else if (state_reg == S_GRP && grp_ack)
      begin
        rsp_valid <= 1'b1;
        rsp_abort <= 1'b0;
        rsp_passthru <= 1'b0;
        rsp_rdata <= (grp_hit && !write_reg) ? grp_rdata : csd_pkg::ALL_ZERO;
      end
      else if (state_reg == S_SBL && sbl_done)
      begin
        rsp_valid <= 1'b1;
        rsp_abort <= sbl_abort;
        rsp_passthru <= 1'b0;
        if (write_reg)
          rsp_rdata <= csd_pkg::ALL_ZERO;
        else
          rsp_rdata <= sbl_abort ? csd_pkg::ALL_ONES : sbl_rdata;
      end
      else if (state_reg == S_MB && mb_done)
      begin
        rsp_valid <= 1'b1;
        rsp_abort <= 1'b0;
        rsp_passthru <= 1'b0;
        rsp_rdata <= write_reg ? csd_pkg::ALL_ZERO : mb_rdata;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  a_bus_zero_only: assert property (take && src_cfg && f_bus != 8'h00 |=> !grp_valid)
    else $error("hub group claimed on non-zero bus");
  a_type1_fwd: assert property (take && src_cfg && f_bus != 8'h00
      |=> sbl_valid && sbl_addr[1:0] == 2'h1 && sbl_addr[31:24] == 8'h00)
    else $error("non-zero bus not sent as type 1");
  a_link_cfg_abort: assert property (take && req_src == csd_pkg::SRC_LINK_CFG
      |=> rsp_valid && rsp_abort && !grp_valid)
    else $error("link configuration request not aborted");
  a_fn_miss_ones: assert property (take && src_cfg && f_bus == 8'h00 && dev_hit && !fn_hit
      && !req_write |=> rsp_valid && rsp_rdata == 32'hffff_ffff)
    else $error("missing function did not read all ones");
  a_reg_miss_zero: assert property (ce && state_reg == S_GRP && grp_ack && !grp_hit
      |=> rsp_valid && rsp_rdata == 32'h0000_0000 && !grp_wcommit)
    else $error("missing register not answered with zeroes");
  a_enable_off_pass: assert property (take && req_src == csd_pkg::SRC_CPU_IO && !latch_en
      && req_addr[15:2] == csd_pkg::IO_CFG_DATA[15:2] |=> rsp_passthru && !grp_valid)
    else $error("data window used while config cycles disabled");
  a_fixed_window: assert property (take && src_fixed && kind == csd_pkg::K_GRP
      |=> grp_valid && grp_dev == 5'h10 && grp_fn == 3'h0 && grp_be == 4'hf
      && grp_dword[9:6] == 4'h0)
    else $error("fixed window not mapped to device 16 function 0");
  a_mb_high_abort: assert property (take && req_src == csd_pkg::SRC_CPU_MEM && win_mb
      && !win_fixed && !win_mcw && !win_ioint && !win_remap
      && req_addr[23:15] != 9'h000 |=> rsp_abort && !mb_valid)
    else $error("memory-buffer access with high bits set not aborted");
  a_latch_reserved: assert property (latch_value[30:24] == 7'h00
      && latch_value[1:0] == 2'h0)
    else $error("reserved latch bits not zero");
  a_port_lanes: assert property (take && kind == csd_pkg::K_GRP && f_dev == 5'h05
      |=> grp_group == csd_pkg::GRP_PCIE_PORT && grp_max_lanes == 5'h10)
    else $error("port 5 lane cap wrong");
  // rising edge only: the pulse stretches while ce is low
  a_commit_after_ack: assert property ($rose(grp_wcommit) |-> $past(grp_ack) && $past(grp_hit)
      && write_reg)
    else $error("write committed without a hit");

  c_group_read: cover property (take && kind == csd_pkg::K_GRP && !req_write);
  c_type1_fwd: cover property (take && kind == csd_pkg::K_SBL ##[1:20] sbl_done);
  c_mb_cmd: cover property (take && kind == csd_pkg::K_MB);
  c_reg_miss: cover property (state_reg == S_GRP && grp_ack && !grp_hit);
endmodule : csd_decoder

// File: test/csd_far_model.sv
/*
  csd_far_model: register groups, southbridge link and memory-buffer agents.
  assumes one request at a time from csd_decoder, all on clk_sys.
*/
`timescale 1ns/100ps
module csd_far_model (
  input wire logic clk_sys,
  input wire logic slow,
  input wire logic grp_valid,
  input wire logic [4:0] grp_dev,
  input wire logic [2:0] grp_fn,
  input wire logic [9:0] grp_dword,
  output logic grp_ack,
  output logic grp_hit,
  output logic [31:0] grp_rdata,
  input wire logic sbl_valid,
  input wire logic [31:0] sbl_addr,
  output logic sbl_done,
  output logic sbl_abort,
  output logic [31:0] sbl_rdata,
  input wire logic mb_valid,
  input wire logic mb_branch,
  input wire logic mb_channel,
  input wire logic [2:0] mb_module_select,
  input wire logic [5:0] mb_dword,
  output logic mb_done,
  output logic [31:0] mb_rdata
);
  logic [1:0] cnt_reg = 2'h0;
  logic go;
  logic [31:0] gpat;
  logic [31:0] mpat;
  // slow mode stalls every answer three cycles
  assign go = !slow || cnt_reg == 2'h3;
  assign gpat = {11'h0, grp_dev, grp_fn, 3'h0, grp_dword};
  assign mpat = {21'h0, mb_branch, mb_channel, mb_module_select, mb_dword};
  always_ff @(posedge clk_sys)
    cnt_reg <= (grp_valid | sbl_valid | mb_valid) ? cnt_reg + 2'h1 : 2'h0;
  always_ff @(posedge clk_sys) grp_ack <= grp_valid & go & !grp_ack;
  always_ff @(posedge clk_sys) sbl_done <= sbl_valid & go & !sbl_done;
  always_ff @(posedge clk_sys) mb_done <= mb_valid & go & !mb_done;
  // offsets from 040h up are unimplemented in every group
  assign grp_hit = grp_dword < 10'h040;
  // idle data lines show the inverse so stale values never match
  assign grp_rdata = grp_ack ? gpat : ~gpat;
  assign sbl_abort = sbl_addr[23:16] == 8'hee;
  assign sbl_rdata = sbl_done ? sbl_addr : ~sbl_addr;
  assign mb_rdata = mb_done ? mpat : ~mpat;
endmodule : csd_far_model

// File: test/csd_decoder_tb.sv
/*
  csd_decoder_tb: directed checks of the configuration space decoder.
  assumes csd_far_model answers the group, link and memory-buffer sides.
*/
`timescale 1ns/100ps
module csd_decoder_tb;
  logic clk_sys = 1'b0, srst = 1'b1, ce = 1'b1, req_valid = 1'b0, req_write = 1'b0, slow = 1'b0;
  csd_pkg::csd_src_type req_src = csd_pkg::SRC_JTAG;
  csd_pkg::csd_group_type grp_group;
  logic [31:0] req_addr = 32'h0, req_wdata = 32'h0, rsp_rdata, grp_wdata, grp_rdata, sbl_addr;
  logic [31:0] sbl_wdata, sbl_rdata, mb_wdata, mb_rdata;
  logic [3:0] req_be = 4'hf, memory_mapped_config_window = 4'he, grp_be, sbl_be, mb_be;
  logic [7:0] req_cfg_bus = 8'h0, memory_buffer_window_base = 8'hd0;
  logic [4:0] req_cfg_dev = 5'h0, grp_dev, grp_max_lanes, ml;
  logic [2:0] req_cfg_fn = 3'h0, grp_fn, mb_module_select;
  logic [9:0] req_cfg_dword = 10'h0, grp_dword;
  logic [5:0] mb_dword;
  logic [19:0] io_interrupt_controller_base = 20'hfec00, remap_window_base = 20'hfed90;
  logic req_ready, rsp_valid, rsp_abort, rsp_passthru, grp_valid, grp_write, grp_ack, grp_hit;
  logic grp_wcommit, sbl_valid, sbl_write, sbl_done, sbl_abort, mb_valid, mb_branch, mb_channel;
  logic mb_write, mb_done;
  int errors = 0, samples_checked = 0;
  byte dl [17] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 13, 14, 16, 17, 18, 21, 22};
  byte fl [17] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 4, 4, 2, 0, 0, 1, 1};
  byte ln [10] = '{0, 16, 4, 8, 4, 16, 4, 8, 4, 4};
  always #20 clk_sys = ~clk_sys;
  csd_decoder DUT (.*);
  csd_far_model far (.*);
  task ck(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : ck
  function logic [31:0] pat(input logic [4:0] d, input logic [2:0] f, input logic [9:0] w);
    return {11'h0, d, f, 3'h0, w};
  endfunction : pat
  // one request held until taken, then a bounded wait for its answer
  task rq(input csd_pkg::csd_src_type s, input logic w, input logic [31:0] a,
      input logic [31:0] wd, input logic [25:0] c);
    int n;
    @(posedge clk_sys) #1;
    req_src = s;
    req_write = w;
    req_addr = a;
    req_wdata = wd;
    {req_cfg_bus, req_cfg_dev, req_cfg_fn, req_cfg_dword} = c;
    req_valid = 1'b1;
    for (n = 0; req_ready !== 1'b1 && n < 50; n++) @(posedge clk_sys) #1;
    @(posedge clk_sys) #1 req_valid = 1'b0;
    ml = grp_max_lanes;
    for (n = 0; rsp_valid !== 1'b1 && n < 50; n++) @(posedge clk_sys) #1;
    ck("rsp_valid", 32'h1, {31'h0, rsp_valid});
  endtask : rq
  task t_io;
    rq(csd_pkg::SRC_CPU_IO, 1'b1, 32'hcf8, 32'hffff_ffff, 26'h0);
    rq(csd_pkg::SRC_CPU_IO, 1'b0, 32'hcf8, 32'h0, 26'h0);
    ck("latch", 32'h80ff_fffc, rsp_rdata);
    rq(csd_pkg::SRC_CPU_IO, 1'b1, 32'hcf8, 32'h0000_800c, 26'h0);
    rq(csd_pkg::SRC_CPU_IO, 1'b0, 32'hcfc, 32'h0, 26'h0);
    ck("passthru", 32'h1, {31'h0, rsp_passthru});
    rq(csd_pkg::SRC_CPU_IO, 1'b1, 32'hcf8, 32'h8000_800c, 26'h0);
    rq(csd_pkg::SRC_CPU_IO, 1'b0, 32'hcfc, 32'h0, 26'h0);
    ck("io data", pat(5'h10, 3'h0, 10'h003), rsp_rdata);
  endtask : t_io
  task t_mem;
    rq(csd_pkg::SRC_CPU_MEM, 1'b0, 32'hfe60_c000, 32'h0, 26'h0);
    ck("fixed", pat(5'h10, 3'h0, 10'h030), rsp_rdata);
    rq(csd_pkg::SRC_CPU_MEM, 1'b0, 32'he008_8014, 32'h0, 26'h0);
    ck("cfg window", pat(5'h11, 3'h0, 10'h005), rsp_rdata);
    rq(csd_pkg::SRC_CPU_MEM, 1'b0, 32'he008_8114, 32'h0, 26'h0);
    ck("no offset", 32'h0, rsp_rdata);
    rq(csd_pkg::SRC_CPU_MEM, 1'b0, 32'he031_1010, 32'h0, 26'h0);
    ck("type1", 32'h0003_1111, rsp_rdata);
    rq(csd_pkg::SRC_CPU_MEM, 1'b0, 32'hfec0_0010, 32'h0, 26'h0);
    ck("ioint", pat(5'h12, 3'h0, 10'h004), rsp_rdata);
    rq(csd_pkg::SRC_LINK_MEM, 1'b0, 32'hfe60_c000, 32'h0, 26'h0);
    ck("link abort", 32'h1, {31'h0, rsp_abort});
    rq(csd_pkg::SRC_LINK_MEM, 1'b0, 32'h1000_0000, 32'h0, 26'h0);
    ck("link pass", 32'h1, {31'h0, rsp_passthru});
    rq(csd_pkg::SRC_LINK_CFG, 1'b0, 32'h0, 32'h0, 26'h0);
    ck("cfg abort", 32'h1, {31'h0, rsp_abort});
    slow = 1'b1;
    rq(csd_pkg::SRC_CPU_MEM, 1'b0, 32'hd000_6404, 32'h0, 26'h0);
    ck("mb", 32'h641, rsp_rdata);
    rq(csd_pkg::SRC_CPU_MEM, 1'b0, 32'hd080_0000, 32'h0, 26'h0);
    ck("mb abort", 32'h1, {31'h0, rsp_abort});
    slow = 1'b0;
  endtask : t_mem
  // writes commit only on a hit; byte enables follow the fixed and config windows
  task t_write;
    rq(csd_pkg::SRC_CPU_MEM, 1'b1, 32'he008_8014, 32'h1234_5678, 26'h0);
    ck("wcommit", 32'h1, {31'h0, grp_wcommit});
    ck("grp_wdata", 32'h1234_5678, grp_wdata);
    ck("grp_write", 32'h1, {31'h0, grp_write});
    ck("grp_group", csd_pkg::GRP_COHERENCY, grp_group);
    rq(csd_pkg::SRC_CPU_MEM, 1'b1, 32'he008_8114, 32'h1234_5678, 26'h0);
    ck("miss wcommit", 32'h0, {31'h0, grp_wcommit});
    rq(csd_pkg::SRC_SMBUS, 1'b1, 32'h0, 32'h5555_aaaa, {8'h0, 5'h11, 3'h1, 10'h001});
    ck("fn miss abort", 32'h1, {31'h0, rsp_abort});
    ck("fn miss claim", 32'h0, {31'h0, grp_valid});
    rq(csd_pkg::SRC_CPU_MEM, 1'b1, 32'he031_1010, 32'hcafe_f00d, 26'h0);
    ck("sbl_wdata", 32'hcafe_f00d, sbl_wdata);
    ck("sbl_write", 32'h1, {31'h0, sbl_write});
    rq(csd_pkg::SRC_CPU_MEM, 1'b1, 32'hd000_6404, 32'h0bad_f00d, 26'h0);
    ck("mb_wdata", 32'h0bad_f00d, mb_wdata);
    ck("mb_write", 32'h1, {31'h0, mb_write});
    rq(csd_pkg::SRC_CPU_MEM, 1'b0, 32'hfed9_0008, 32'h0, 26'h0);
    ck("remap", pat(5'h00, 3'h0, 10'h002), rsp_rdata);
    ck("remap group", csd_pkg::GRP_REMAP, grp_group);
    req_be = 4'h3;
    rq(csd_pkg::SRC_CPU_MEM, 1'b0, 32'hfe60_c400, 32'h0, 26'h0);
    ck("fixed be", 32'hf, {28'h0, grp_be});
    rq(csd_pkg::SRC_CPU_MEM, 1'b0, 32'he008_8014, 32'h0, 26'h0);
    ck("window be", 32'h3, {28'h0, sbl_be});
    ck("mb_be", 32'h3, {28'h0, mb_be});
    req_be = 4'hf;
  endtask : t_write
  // last implemented function of each device answers, the next one aborts
  task t_table;
    logic [4:0] d;
    logic [2:0] f;
    for (int i = 0; i < 17; i++)
    begin
      d = dl[i][4:0];
      f = fl[i][2:0];
      rq(csd_pkg::SRC_JTAG, 1'b0, 32'h0, 32'h0, {8'h0, d, f, 10'h001});
      ck("group", pat(d, f, 10'h001), rsp_rdata);
      if (i > 0 && i < 10)
        ck("lanes", {24'h0, ln[i]}, {27'h0, ml});
      rq(csd_pkg::SRC_SMBUS, 1'b0, 32'h0, 32'h0, {8'h0, d, f + 3'h1, 10'h001});
      ck("ones", 32'hffff_ffff, rsp_rdata);
    end
  endtask : t_table
  task tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (5) @(posedge clk_sys);
    #1 srst = 1'b0;
    t_io;
    t_mem;
    t_write;
    t_table;
    tally_and_finish;
  end
  // about 190 cycles needed; 2500 allowed
  initial
  begin
    #100000;
    errors++;
    tally_and_finish;
  end
endmodule : csd_decoder_tb
